// >>> src/timer16_cfg.svh
// Offsets, field positions, reset values and bus codes of the timer block.
// Assumes inclusion by bare name; definitions only.
`ifndef TIMER16_CFG_SVH
`define TIMER16_CFG_SVH

// Channel count and AXI address width
`define T16_CH_NUM        3
`define T16_ADDR_W        12

// Register indices; byte address is four times the index
`define T16_CH_STRIDE     7'h20
`define T16_IDX_CLK       5'h00
`define T16_IDX_TR        5'h02
`define T16_IDX_TC        5'h04
`define T16_IDX_CTL       5'h06
`define T16_IDX_INT       5'h08

// Control register fields
`define T16_CTL_RUN       0
`define T16_CTL_PRESET    1
`define T16_CTL_COUNT_MODE_SELECT      4
`define T16_CTL_POL       9
`define T16_CTL_MODE_LSB  10

// Interrupt register fields
`define T16_INT_FLAG      0
`define T16_INT_IE        8

// Reset values
`define T16_DIV_RST       4'h0
`define T16_POL_RST       1'b1
`define T16_CNT_RST       16'hffff
`define T16_RELOAD_RST    16'h0000

// Reserved divider code and prescaler width
`define T16_DIV_RESERVED  4'hf
`define T16_PRESC_W       14

// AXI responses
`define AXI_RESP_OKAY     2'h0
`define AXI_RESP_SLVERR   2'h2

`endif

// >>> src/timer16_pkg.sv
// Types shared by the timer top, its channel and the channel interface.
// Assumes the cfg header supplies all numeric constants.
package timer16_pkg;

    // Operating modes in field order: internal, external, pulse width, spare
    typedef enum logic [1:0] {
        mode_internal,
        mode_external,
        mode_pulse_width,
        mode_reserved
    } op_mode_e;

    typedef logic [15:0] count_t;
    typedef logic [3:0]  divide_t;

endpackage

// >>> src/timer16_chan_if.sv
// Carrier between the register file and one timer channel.
// Assumes one clock domain; all signals are synchronous to sys_clk.
`timescale 1ns/1ps
interface timer16_chan_if;
    import timer16_pkg::*;

    op_mode_e op_mode_select;
    divide_t  clock_divide_select;
    logic     input_polarity;
    logic     count_mode_select;
    count_t   reload;
    logic     run_wr;
    logic     run_wdata;
    logic     counter_preset;
    logic     ext_level;
    count_t   count;
    logic     running;
    logic     underflow;

    // Register side drives configuration, channel answers with state
    modport regs (
        output op_mode_select, clock_divide_select, input_polarity,
        output count_mode_select, reload, run_wr, run_wdata,
        output counter_preset, ext_level,
        input  count, running, underflow
    );
    modport chan (
        input  op_mode_select, clock_divide_select, input_polarity,
        input  count_mode_select, reload, run_wr, run_wdata,
        input  counter_preset, ext_level,
        output count, running, underflow
    );
endinterface

// >>> src/timer16_channel.sv
// One 16-bit down-counting timer channel with prescaler and pin gating.
// Assumes ext_level is already synchronised to sys_clk by the top.
`timescale 1ns/1ps
`include "timer16_cfg.svh"
module timer16_channel (
    // Clock and reset
    input  wire logic              sys_clk,
    input  wire logic              reset_n,
    // Register side
    timer16_chan_if.chan           cif
);
    import timer16_pkg::*;

    // Low-bit mask of the prescaler for a divide-by-2^n selection
    function automatic logic [`T16_PRESC_W-1:0] presc_mask(
        input divide_t sel
    );
        logic [`T16_PRESC_W:0] wide;
        wide = ({{`T16_PRESC_W{1'b0}}, 1'b1} << sel)
             - {{`T16_PRESC_W{1'b0}}, 1'b1};
        return wide[`T16_PRESC_W-1:0];
    endfunction

    count_t                  count_reg;
    count_t                  count_next;
    logic                    run_reg;
    logic                    run_next;
    logic                    uf_reg;
    logic                    ext_prev_reg;
    logic [`T16_PRESC_W-1:0] presc_reg;

    wire logic [`T16_PRESC_W-1:0] mask = presc_mask(cif.clock_divide_select);
    wire logic div_ok  = cif.clock_divide_select != `T16_DIV_RESERVED;
    // Divided count clock as a one-cycle enable; reserved ratio never ticks
    wire logic tick    = div_ok && ((presc_reg & mask) == mask);
    wire logic rise    = cif.ext_level && !ext_prev_reg;
    wire logic fall    = !cif.ext_level && ext_prev_reg;
    wire logic edge_ok = cif.input_polarity ? rise : fall;
    wire logic active  = cif.ext_level == cif.input_polarity;

    // Mode selects which event decrements; spare mode is frozen
    logic step;
    always_comb begin
        case (cif.op_mode_select)
            mode_internal:    step = tick;
            mode_external:    step = div_ok && edge_ok;
            mode_pulse_width: step = tick && active;
            default:          step = 1'b0;
        endcase
    end

    wire logic do_step = run_reg && step;
    wire logic hit_uf  = do_step && (count_reg == 16'h0000);

    // Underflow reloads; one-shot drops run, a run write overrides it
    always_comb begin
        count_next = count_reg;
        run_next   = run_reg;
        if (cif.counter_preset) begin
            count_next = cif.reload;
        end else if (hit_uf) begin
            count_next = cif.reload;
        end else if (do_step) begin
            count_next = count_reg - 16'h0001;
        end
        if (hit_uf && cif.count_mode_select) begin
            run_next = 1'b0;
        end
        if (cif.run_wr) begin
            run_next = cif.run_wdata;
        end
    end

    // Prescaler free-runs only while running, so stop freezes the phase
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            count_reg    <= `T16_CNT_RST;
            run_reg      <= 1'b0;
            uf_reg       <= 1'b0;
            ext_prev_reg <= 1'b0;
            presc_reg    <= '0;
        end else begin
            count_reg    <= count_next;
            run_reg      <= run_next;
            uf_reg       <= hit_uf;
            ext_prev_reg <= cif.ext_level;
            presc_reg    <= run_reg ? presc_reg + 1'b1 : presc_reg;
        end
    end

    assign cif.count     = count_reg;
    assign cif.running   = run_reg;
    assign cif.underflow = uf_reg;
endmodule

// >>> src/timer16_top.sv
// Three-channel 16-bit timer with an AXI4-Lite register slave.
// Assumes sys_clk is the delivered peripheral clock; count pins are async.
`timescale 1ns/1ps
`include "timer16_cfg.svh"
module timer16_top (
    // Clock and reset
    input  wire logic                     sys_clk,
    input  wire logic                     reset_n,
    // AXI4-Lite write address
    input  wire logic [`T16_ADDR_W-1:0]   s_axi_awaddr,
    input  wire logic                     s_axi_awvalid,
    output logic                          s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]              s_axi_wdata,
    input  wire logic [3:0]               s_axi_wstrb,
    input  wire logic                     s_axi_wvalid,
    output logic                          s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]                    s_axi_bresp,
    output logic                          s_axi_bvalid,
    input  wire logic                     s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [`T16_ADDR_W-1:0]   s_axi_araddr,
    input  wire logic                     s_axi_arvalid,
    output logic                          s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]                   s_axi_rdata,
    output logic [1:0]                    s_axi_rresp,
    output logic                          s_axi_rvalid,
    input  wire logic                     s_axi_rready,
    // External count pins, one per channel
    input  wire logic [`T16_CH_NUM-1:0]   ext_count_input,
    // Underflow pulses to ADC, SPI and I2C clocks, and interrupt requests
    output logic [`T16_CH_NUM-1:0]        underflow_pulse,
    output logic [`T16_CH_NUM-1:0]        underflow_irq
);
    import timer16_pkg::*;

    // Register address to channel and index; ok is low for holes
    function automatic logic [7:0] reg_decode(
        input logic [`T16_ADDR_W-1:0] addr
    );
        logic [6:0] idx;
        logic [1:0] ch;
        logic [4:0] rsel;
        logic       ok;
        idx  = addr[8:2];
        ch   = idx[6:5];
        rsel = idx[4:0];
        ok   = (addr[`T16_ADDR_W-1:9] == '0) && (ch < 2'd3)
            && (rsel == `T16_IDX_CLK || rsel == `T16_IDX_TR
             || rsel == `T16_IDX_TC  || rsel == `T16_IDX_CTL
             || rsel == `T16_IDX_INT);
        return {ok, ch, rsel};
    endfunction

    // Per-channel software state
    op_mode_e mode_reg   [`T16_CH_NUM];
    divide_t  div_reg    [`T16_CH_NUM];
    logic     pol_reg    [`T16_CH_NUM];
    logic     count_mode_select_reg   [`T16_CH_NUM];
    count_t   reload_reg [`T16_CH_NUM];
    logic     ie_reg     [`T16_CH_NUM];
    logic     flag_reg   [`T16_CH_NUM];
    logic [`T16_CH_NUM-1:0] irq_reg;

    // Pin synchronisers: stage one feeds stage two only
    logic [`T16_CH_NUM-1:0] pin_meta_reg;
    logic [`T16_CH_NUM-1:0] pin_sync_reg;
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            pin_meta_reg <= '0;
            pin_sync_reg <= '0;
        end else begin
            pin_meta_reg <= ext_count_input;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    // AXI write side: address and data latched in either order
    logic                   aw_held_reg;
    logic                   w_held_reg;
    logic [`T16_ADDR_W-1:0] waddr_reg;
    logic [31:0]            wdata_reg;
    logic [3:0]             wstrb_reg;
    logic                   bvalid_reg;
    logic [1:0]             bresp_reg;

    wire logic       aw_take  = s_axi_awvalid && s_axi_awready;
    wire logic       w_take   = s_axi_wvalid && s_axi_wready;
    wire logic       do_write = aw_held_reg && w_held_reg && !bvalid_reg;
    wire logic [7:0] wdec     = reg_decode(waddr_reg);
    wire logic       w_ok     = wdec[7];
    wire logic [1:0] w_ch     = wdec[6:5];
    wire logic [4:0] w_sel    = wdec[4:0];
    wire logic       lane0    = wstrb_reg[0];
    wire logic       lane1    = wstrb_reg[1];

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            waddr_reg   <= '0;
            wdata_reg   <= 32'h0000_0000;
            wstrb_reg   <= 4'h0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= `AXI_RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_held_reg <= 1'b1;
                waddr_reg   <= s_axi_awaddr;
            end
            if (w_take) begin
                w_held_reg <= 1'b1;
                wdata_reg  <= s_axi_wdata;
                wstrb_reg  <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held_reg <= 1'b0;
                w_held_reg  <= 1'b0;
                bvalid_reg  <= 1'b1;
                bresp_reg   <= w_ok ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
            end else if (bvalid_reg && s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    // Ready stays low while a beat is held, so one write at a time
    logic aw_ready_reg;
    logic w_ready_reg;
    assign s_axi_awready = aw_ready_reg;
    assign s_axi_wready  = w_ready_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            aw_ready_reg <= 1'b0;
            w_ready_reg  <= 1'b0;
        end else begin
            aw_ready_reg <= !aw_held_reg && !aw_take && !bvalid_reg
                         && !do_write;
            w_ready_reg  <= !w_held_reg && !w_take && !bvalid_reg
                         && !do_write;
        end
    end

    // Read address decoded ahead so each channel can offer its word
    wire logic [7:0] rdec    = reg_decode(s_axi_araddr);
    wire logic [4:0] cur_sel = rdec[4:0];

    // Channels and their control registers
    timer16_chan_if cif [`T16_CH_NUM] ();
    logic [15:0] rd_word [`T16_CH_NUM];

    for (genvar c = 0; c < `T16_CH_NUM; c++) begin : g_ch
        wire logic hit   = do_write && w_ok && (w_ch == 2'(c)) && lane0;
        wire logic ctl_w = hit && (w_sel == `T16_IDX_CTL);
        wire logic int_w = hit && (w_sel == `T16_IDX_INT);
        wire logic uf    = cif[c].underflow;

        // Divider changes are taken as written; stopping first is up to
        // software, a change mid-count only shifts one period
        always_ff @(posedge sys_clk or negedge reset_n) begin
            if (!reset_n) begin
                mode_reg[c]   <= mode_internal;
                div_reg[c]    <= `T16_DIV_RST;
                pol_reg[c]    <= `T16_POL_RST;
                count_mode_select_reg[c]   <= 1'b0;
                reload_reg[c] <= `T16_RELOAD_RST;
                ie_reg[c]     <= 1'b0;
                flag_reg[c]   <= 1'b0;
                irq_reg[c]    <= 1'b0;
            end else begin
                if (hit && w_sel == `T16_IDX_CLK) begin
                    div_reg[c] <= wdata_reg[3:0];
                end
                if (hit && w_sel == `T16_IDX_TR) begin
                    reload_reg[c][7:0] <= wdata_reg[7:0];
                end
                if (do_write && w_ok && w_ch == 2'(c) && lane1
                    && w_sel == `T16_IDX_TR) begin
                    reload_reg[c][15:8] <= wdata_reg[15:8];
                end
                if (ctl_w) begin
                    count_mode_select_reg[c] <= wdata_reg[`T16_CTL_COUNT_MODE_SELECT];
                end
                if (ctl_w && lane1) begin
                    pol_reg[c]  <= wdata_reg[`T16_CTL_POL];
                    mode_reg[c] <= op_mode_e'(
                        wdata_reg[`T16_CTL_MODE_LSB +: 2]);
                end
                if (do_write && w_ok && w_ch == 2'(c) && lane1
                    && w_sel == `T16_IDX_INT) begin
                    ie_reg[c] <= wdata_reg[`T16_INT_IE];
                end
                // Set wins over a same-cycle clear
                if (uf) begin
                    flag_reg[c] <= 1'b1;
                end else if (int_w && wdata_reg[`T16_INT_FLAG]) begin
                    flag_reg[c] <= 1'b0;
                end
                irq_reg[c] <= (flag_reg[c] || uf) && ie_reg[c];
            end
        end

        assign cif[c].op_mode_select      = mode_reg[c];
        assign cif[c].clock_divide_select = div_reg[c];
        assign cif[c].input_polarity      = pol_reg[c];
        assign cif[c].count_mode_select   = count_mode_select_reg[c];
        assign cif[c].reload              = reload_reg[c];
        assign cif[c].run_wr              = ctl_w;
        assign cif[c].run_wdata           = wdata_reg[`T16_CTL_RUN];
        assign cif[c].counter_preset = ctl_w && wdata_reg[`T16_CTL_PRESET];
        assign cif[c].ext_level           = pin_sync_reg[c];

        // Preset bit is write-only and reads as zero
        wire logic [15:0] ctl_rd = {4'h0, mode_reg[c], pol_reg[c], 4'h0,
                                    count_mode_select_reg[c], 3'h0, cif[c].running};
        wire logic [15:0] int_rd = {7'h00, ie_reg[c], 7'h00, flag_reg[c]};
        assign rd_word[c] =
              (cur_sel == `T16_IDX_CLK) ? {12'h000, div_reg[c]}
            : (cur_sel == `T16_IDX_TR)  ? reload_reg[c]
            : (cur_sel == `T16_IDX_TC)  ? cif[c].count
            : (cur_sel == `T16_IDX_CTL) ? ctl_rd
            : int_rd;

        timer16_channel u_chan (
            .sys_clk (sys_clk),
            .reset_n (reset_n),
            .cif     (cif[c])
        );

        assign underflow_pulse[c] = cif[c].underflow;
    end

    assign underflow_irq = irq_reg;

    // AXI read side: one read at a time, data registered with the answer
    logic        ar_ready_reg;
    logic        rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0]  rresp_reg;

    wire logic       ar_take = s_axi_arvalid && ar_ready_reg;
    wire logic [15:0] sel_word =
          (rdec[6:5] == 2'd0) ? rd_word[0]
        : (rdec[6:5] == 2'd1) ? rd_word[1]
        : rd_word[2];

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ar_ready_reg <= 1'b0;
            rvalid_reg   <= 1'b0;
            rdata_reg    <= 32'h0000_0000;
            rresp_reg    <= `AXI_RESP_OKAY;
        end else begin
            ar_ready_reg <= !rvalid_reg && !ar_take;
            if (ar_take) begin
                rvalid_reg <= 1'b1;
                rdata_reg  <= rdec[7] ? {16'h0000, sel_word} : 32'h0000_0000;
                rresp_reg  <= rdec[7] ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
            end else if (rvalid_reg && s_axi_rready) begin
                rvalid_reg <= 1'b0;
            end
        end
    end

    assign s_axi_arready = ar_ready_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;

    // Peripheral clock delivery is assumed: sys_clk is that clock
    // Pin direction is port logic outside this block
endmodule

// >>> test/timer16_top_assertions.sv
// Port checks on the AXI4-Lite slave of the three-channel timer.
// Assumes one clock domain and the cfg header on the include path.
`timescale 1ns/1ps
`include "timer16_cfg.svh"
module timer16_top_assertions (
    // Clock and reset
    input wire logic                   sys_clk,
    input wire logic                   reset_n,
    // Write side
    input wire logic [`T16_ADDR_W-1:0] s_axi_awaddr,
    input wire logic                   s_axi_awvalid,
    input wire logic                   s_axi_awready,
    input wire logic                   s_axi_wvalid,
    input wire logic                   s_axi_wready,
    input wire logic [1:0]             s_axi_bresp,
    input wire logic                   s_axi_bvalid,
    input wire logic                   s_axi_bready,
    // Read side
    input wire logic [`T16_ADDR_W-1:0] s_axi_araddr,
    input wire logic                   s_axi_arvalid,
    input wire logic                   s_axi_arready,
    input wire logic [31:0]            s_axi_rdata,
    input wire logic [1:0]             s_axi_rresp,
    input wire logic                   s_axi_rvalid,
    input wire logic                   s_axi_rready
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    // Odd indices and channel slots above two hold no register
    wire aw_go  = s_axi_awvalid && s_axi_awready
               && s_axi_wvalid && s_axi_wready;
    wire ar_go  = s_axi_arvalid && s_axi_arready;
    wire w_hole = s_axi_awaddr[2] || s_axi_awaddr[11:7] > 5'h02;
    wire r_hole = s_axi_araddr[2] || s_axi_araddr[11:7] > 5'h02;

    chk_b_latency: assert property (aw_go |-> ##2 s_axi_bvalid)
        else $error("write answer not on time");
    chk_b_slverr: assert property (aw_go && w_hole |-> ##2
        s_axi_bresp == `AXI_RESP_SLVERR) else $error("hole write not refused");
    chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
    chk_r_hole: assert property (ar_go && r_hole |=>
        s_axi_rvalid && s_axi_rresp == `AXI_RESP_SLVERR
        && s_axi_rdata == 32'h0) else $error("hole read not refused");
    chk_r_okay: assert property (ar_go && !r_hole |=>
        s_axi_rvalid && s_axi_rresp == `AXI_RESP_OKAY
        && s_axi_rdata[31:16] == 16'h0) else $error("mapped read wrong");
    chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
    chk_ar_block: assert property (s_axi_rvalid |->
        !s_axi_arready) else $error("read taken while answering");
    chk_w_return: assert property (s_axi_bvalid && s_axi_bready
        |-> ##2 s_axi_awready && s_axi_wready) else $error("write ready late");
    chk_r_return: assert property (s_axi_rvalid && s_axi_rready
        |-> ##2 s_axi_arready) else $error("read ready late");
endmodule

bind timer16_top timer16_top_assertions chk (
    .sys_clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
);

// >>> test/count_pin_source.sv
// Source of the three external count pins, idle low between bursts.
// Assumes the bench calls its tasks right after a rising clock edge.
`timescale 1ns/1ps
module count_pin_source (
    // Clock
    input  wire logic sys_clk,
    // Pins, inputs only on the port side
    output logic [2:0] pins
);
    initial pins = 3'h0;
    // Each pulse gives one rising and one falling edge
    task automatic pulses(input int c, input int n);
        repeat (n) begin
            repeat (4) @(posedge sys_clk);
            pins[c] <= 1'b1;
            repeat (4) @(posedge sys_clk);
            pins[c] <= 1'b0;
        end
    endtask
    // Gate level held for n cycles
    task automatic level(input int c, input logic v, input int n);
        pins[c] <= v;
        repeat (n) @(posedge sys_clk);
    endtask
endmodule

// >>> test/sixteen_bit_timer_multimode_tb.sv
// Self-checking bench for the three-channel timer over AXI4-Lite.
// Assumes the pin source model and the bound port checker.
`timescale 1ns/1ps
`include "timer16_cfg.svh"
module sixteen_bit_timer_multimode_tb;
    localparam int I_CLK = `T16_IDX_CLK, I_TR = `T16_IDX_TR;
    localparam int I_TC = `T16_IDX_TC, I_CTL = `T16_IDX_CTL;
    localparam int I_INT = `T16_IDX_INT;
    logic sys_clk = 0, reset_n = 0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [11:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, rnd;
    logic [1:0]  bresp, rresp;
    logic awready, wready, bvalid, arready, rvalid;
    logic [2:0]  pins, pulse, irq;
    logic [1:0]  bq[$];
    logic [33:0] rq[$];
    int failures = 0, num_checks = 0, pc[3] = '{0, 0, 0};
    int c, j, k, p0, trs[3], dv[3] = '{0, 1, 3};

    timer16_top dut (.sys_clk(sys_clk), .reset_n(reset_n),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .ext_count_input(pins),
        .underflow_pulse(pulse), .underflow_irq(irq));
    count_pin_source src (.sys_clk(sys_clk), .pins(pins));

    always #12.5 sys_clk = ~sys_clk;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [11:0] ad(input int ch, input int i);
        return 12'(ch * 128 + i * 4);
    endfunction
    task automatic check(input string nm, input logic [31:0] e, g);
        num_checks++;
        if (g !== e) begin
            failures++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic results();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // One bus transfer; readies sampled mid-cycle, released after the edge
    task automatic bus(input logic w, input logic [11:0] a,
                       input logic [31:0] d, input logic [33:0] e);
        logic r1, r2, r3, b;
        if (w) bq.push_back(e[33:32]);
        else rq.push_back(e);
        @(posedge sys_clk);
        awaddr <= a;
        araddr <= a;
        wdata <= d;
        awvalid <= w;
        wvalid <= w;
        bready <= w;
        arvalid <= !w;
        rready <= !w;
        for (int n = 0; n < 100; n++) begin
            @(negedge sys_clk);
            r1 = awready;
            r2 = wready;
            r3 = arready;
            b = w ? bvalid : rvalid;
            @(posedge sys_clk);
            if (r1) awvalid <= 0;
            if (r2) wvalid <= 0;
            if (r3) arvalid <= 0;
            if (b) begin
                bready <= 0;
                rready <= 0;
                return;
            end
        end
        failures++;
        results();
    endtask
    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        bus(1, a, {16'h0, d}, {`AXI_RESP_OKAY, 32'h0});
    endtask
    task automatic rd(input logic [11:0] a, input logic [15:0] d);
        bus(0, a, 0, {`AXI_RESP_OKAY, 16'h0, d});
    endtask
    task automatic wpulse(input int ch, output int n);
        for (n = 1; n < 5000; n++) begin
            @(negedge sys_clk);
            if (pulse[ch] === 1'b1) return;
        end
        failures++;
        results();
    endtask

    // Answers matched against the oldest note
    always @(negedge sys_clk) begin
        if (bvalid && bready) check("bresp", bq.pop_front(), bresp);
        if (rvalid && rready) begin
            check("rdata", rq[0][31:0], rdata);
            check("rresp", rq.pop_front() >> 32, rresp);
        end
    end
    // Pulses counted mid-cycle, so no race with the main sequence
    always @(negedge sys_clk)
        for (int i = 0; i < 3; i++) if (pulse[i] === 1'b1) pc[i]++;

    initial begin
        rnd = 32'h0cc38ef5;
        repeat (16) @(posedge sys_clk);
        reset_n <= 1;
        repeat (2) @(posedge sys_clk);
        // Every channel: reset values, random reload, three dividers
        for (c = 0; c < 3; c++) begin
            rd(ad(c, I_CLK), 0);
            rd(ad(c, I_TR), 0);
            rd(ad(c, I_TC), 16'hffff);
            rd(ad(c, I_CTL), 16'h0200);
            rd(ad(c, I_INT), 0);
            rnd = lfsr(rnd);
            trs[c] = 2 + rnd[2:0];
            wr(ad(c, I_TR), trs[c]);
            rd(ad(c, I_TR), trs[c]);
            for (j = 0; j < 3; j++) begin
                wr(ad(c, I_CLK), dv[j]); // Stopped first
                wr(ad(c, I_CTL), 2);
                wr(ad(c, I_CTL), 1);
                wpulse(c, k);
                wpulse(c, k);
                check("period", (trs[c] + 1) << dv[j], k);
                wr(ad(c, I_CTL), 0);
            end
            p0 = pc[c];
            repeat (40) @(posedge sys_clk);
            check("held", p0, pc[c]);
        end
        // One-shot, then flag and enable
        wr(ad(0, I_INT), 1);
        wr(ad(0, I_CTL), 16'h0012);
        wr(ad(0, I_CTL), 16'h0011);
        wpulse(0, k);
        repeat (4) @(posedge sys_clk);
        rd(ad(0, I_CTL), 16'h0010);
        rd(ad(0, I_TC), trs[0]);
        rd(ad(0, I_INT), 1);
        wr(ad(0, I_INT), 16'h0100);
        repeat (2) @(negedge sys_clk);
        check("irq on", 1, irq[0]);
        wr(ad(0, I_INT), 16'h0101);
        repeat (2) @(negedge sys_clk);
        check("irq clr", 0, irq[0]);
        // Reserved mode, then reserved divider
        for (j = 0; j < 2; j++) begin
            wr(ad(0, I_CLK), j ? 15 : 3);
            wr(ad(0, I_CTL), j ? 16'h0002 : 16'h0c02);
            wr(ad(0, I_CTL), j ? 16'h0001 : 16'h0c01);
            p0 = pc[0];
            repeat (60) @(posedge sys_clk);
            rd(ad(0, I_TC), trs[0]);
            check("frozen", p0, pc[0]);
            wr(ad(0, I_CTL), 0);
        end
        // Event counting on rising, then falling edges
        for (j = 0; j < 2; j++) begin
            wr(ad(1, I_TR), 2);
            wr(ad(1, I_CTL), j ? 16'h0402 : 16'h0602);
            wr(ad(1, I_CTL), j ? 16'h0401 : 16'h0601);
            p0 = pc[1];
            src.pulses(1, 6);
            repeat (10) @(posedge sys_clk);
            check("events", p0 + 2, pc[1]);
        end
        // Gated counting, high active at 1/2, low active at 1/1
        for (j = 0; j < 2; j++) begin
            wr(ad(2, I_TR), 4);
            wr(ad(2, I_CLK), j ? 0 : 1);
            src.level(2, j, 4);
            wr(ad(2, I_CTL), j ? 16'h0802 : 16'h0a02);
            wr(ad(2, I_CTL), j ? 16'h0801 : 16'h0a01);
            p0 = pc[2];
            src.level(2, !j, 22);
            src.level(2, j, 30);
            check("width", p0 + (j ? 4 : 2), pc[2]);
            wr(ad(2, I_CTL), 0); // Stopped before divider change
        end
        // Holes in the map
        bus(0, ad(0, 1), 0, {`AXI_RESP_SLVERR, 32'h0});
        bus(0, 12'h180, 0, {`AXI_RESP_SLVERR, 32'h0});
        bus(1, ad(1, 1), 1, {`AXI_RESP_SLVERR, 32'h0});
        results();
    end
endmodule
